// ### pkg/tpec_pkg.sv
// Constants shared by the counter configuration block and its prescaler.
package tpec_pkg;
  // Register word indices; the byte address is four times the index.
  localparam int unsigned IDX_W     = 30;
  localparam logic [29:0] IDX_CTRL  = 30'h0000_0005;
  localparam logic [29:0] IDX_STS   = 30'h0000_0006;
  localparam logic [29:0] IDX_MASK  = 30'h0000_0007;
  localparam logic [29:0] IDX_CNT   = 30'h0000_0008;
  // Control register layout.
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned CTRL_EXT_EDGE = 7;
  localparam int unsigned CTRL_CNT_EDGE = 6;
  localparam int unsigned CTRL_SRC      = 5;
  localparam int unsigned CTRL_PS_LSB   = 1;
  localparam int unsigned PS_W          = 4;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_WMASK    = 8'hFE;
  // Status and mask layout.
  localparam int unsigned STS_W   = 3;
  localparam int unsigned STS_EXT = 0;
  localparam int unsigned STS_PIN = 1;
  localparam int unsigned STS_OVF = 2;
  localparam logic [2:0]  STS_RESET = 3'h0;
  // Internal instruction clock is the system clock divided by four.
  localparam int unsigned INT_DIV_W = 2;
  localparam logic [1:0]  INT_DIV_LAST = 2'h3;
  // Counter and prescaler widths.
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PSC_W = 8;
  localparam int unsigned HTRANS_ACTIVE = 1;
endpackage

// ### pkg/tpec_psc_if.sv
// Link between the configuration block and its prescaler.
`timescale 1ns/100ps
interface tpec_psc_if;
  logic       tick;
  logic [3:0] sel;
  logic       div_toggle;
  modport ctrl (output tick, output sel, input div_toggle);
  modport psc  (input tick, input sel, output div_toggle);
endinterface

// ### hdl/tpec_prescaler.sv
// Power-of-two prescaler that flips a toggle once per divided period.
`timescale 1ns/100ps
module tpec_prescaler #(
  parameter int unsigned PSC_W = tpec_pkg::PSC_W
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Tick in, divided toggle out.
  tpec_psc_if.psc   bus
);
  logic [PSC_W-1:0] cnt_q;
  logic [PSC_W-1:0] cnt_d;
  logic             tog_q;
  logic [PSC_W-1:0] mask;
  logic             done;

  // A select with its top bit set means the full divide by 256.
  assign mask = bus.sel[3] ? {PSC_W{1'b1}} :
                PSC_W'((PSC_W'(1) << bus.sel[2:0]) - PSC_W'(1));
  assign done = bus.tick & ((cnt_q & mask) == mask);
  assign cnt_d = bus.tick ? PSC_W'(cnt_q + PSC_W'(1)) : cnt_q;
  assign bus.div_toggle = tog_q;

  // The count free-runs; only its low bits are compared.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tog_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tog_q <= tog_q ^ done;
    end
  end

  chk_psc_unity: assert property (@(posedge clk) disable iff (rst)
    (bus.tick && bus.sel == 4'h0) |=> (tog_q != $past(tog_q)))
    else $error("Prescaler 1:1 did not pass a tick.");
  chk_psc_full: assert property (@(posedge clk) disable iff (rst)
    (bus.tick && bus.sel[3] && cnt_q != {PSC_W{1'b1}}) |=>
      (tog_q == $past(tog_q)))
    else $error("Prescaler 1:256 fired early.");
endmodule

// ### hdl/tpec_top.sv
// Counter clock configuration register, prescaled counter and interrupts.
`timescale 1ns/100ps
module tpec_top (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pins.
  input  wire logic        ext_irq_pin,
  input  wire logic        count_clock_pin,
  // Interrupt.
  output logic             irq
);
  localparam int unsigned CW = tpec_pkg::CNT_W;
  localparam int unsigned SW = tpec_pkg::STS_W;

  tpec_psc_if psc_bus ();

  logic [tpec_pkg::CTRL_W-1:0]     ctrl_q;
  logic [tpec_pkg::CTRL_W-1:0]     ctrl_d;
  logic [SW-1:0]                   sts_q;
  logic [SW-1:0]                   sts_d;
  logic [SW-1:0]                   mask_q;
  logic [SW-1:0]                   mask_d;
  logic [CW-1:0]                   cnt_q;
  logic [CW-1:0]                   cnt_d;
  logic [tpec_pkg::INT_DIV_W-1:0]  div_q;
  logic                            int_tick;
  logic                            ext_prev_q;
  logic                            pin_prev_q;
  logic                            sync1_q;
  logic                            sync2_q;
  logic                            sync3_q;
  logic                            wr_q;
  logic [tpec_pkg::IDX_W-1:0]      idx_q;
  logic [31:0]                     hrdata_q;
  logic                            hreadyout_q;
  logic                            hresp_q;
  logic                            irq_q;

  // Bus decode.
  logic                            acc;
  logic                            wr_ctrl;
  logic                            wr_sts;
  logic                            wr_mask;
  logic [tpec_pkg::IDX_W-1:0]      idx_a;
  logic [31:0]                     rd_mux;
  logic [SW-1:0]                   w1c;

  // Event decode.
  logic                            ext_edge;
  logic                            pin_edge;
  logic                            ext_rise;
  logic                            ext_fall;
  logic                            pin_rise;
  logic                            pin_fall;
  logic                            cnt_step;
  logic                            cnt_wrap;
  logic [SW-1:0]                   set_ev;

  // The address phase is taken when the bus is ready and the slot is ours.
  assign acc     = hsel & htrans[tpec_pkg::HTRANS_ACTIVE] & hready;
  assign idx_a   = haddr[31:2];
  assign wr_ctrl = wr_q & (idx_q == tpec_pkg::IDX_CTRL);
  assign wr_sts  = wr_q & (idx_q == tpec_pkg::IDX_STS);
  assign wr_mask = wr_q & (idx_q == tpec_pkg::IDX_MASK);

  // Bit 0 is never stored, so it can only read back as zero.
  assign ctrl_d = wr_ctrl ?
                  (hwdata[tpec_pkg::CTRL_W-1:0] & tpec_pkg::CTRL_WMASK) :
                  ctrl_q;
  assign mask_d = wr_mask ? hwdata[SW-1:0] : mask_q;
  assign w1c    = wr_sts ? hwdata[SW-1:0] : '0;
  // A new event beats a clear arriving in the same cycle.
  assign sts_d  = (sts_q & ~w1c) | set_ev;

  // Reads see next-state values so a read right after a write is current.
  // Narrow registers are zero-extended so the upper bits read as zero.
  assign rd_mux =
    (idx_a == tpec_pkg::IDX_CTRL) ? 32'(ctrl_d) :
    (idx_a == tpec_pkg::IDX_STS)  ? 32'(sts_d) :
    (idx_a == tpec_pkg::IDX_MASK) ? 32'(mask_d) :
    (idx_a == tpec_pkg::IDX_CNT)  ? 32'(cnt_d) : 32'h0000_0000;

  // External interrupt pin edge, polarity from bit 7.
  assign ext_rise = ext_irq_pin & ~ext_prev_q;
  assign ext_fall = ~ext_irq_pin & ext_prev_q;
  assign ext_edge = ctrl_q[tpec_pkg::CTRL_EXT_EDGE] ? ext_rise :
                    ext_fall;

  // Counter pin edge, polarity from bit 6.
  assign pin_rise = count_clock_pin & ~pin_prev_q;
  assign pin_fall = ~count_clock_pin & pin_prev_q;
  assign pin_edge = ctrl_q[tpec_pkg::CTRL_CNT_EDGE] ? pin_rise :
                    pin_fall;

  // Internal instruction clock tick, one system clock in four.
  assign int_tick = (div_q == tpec_pkg::INT_DIV_LAST);

  // Source select feeds raw edges into the prescaler ahead of the sync.
  assign psc_bus.tick = ctrl_q[tpec_pkg::CTRL_SRC] ? int_tick :
                        pin_edge;
  assign psc_bus.sel  = ctrl_q[tpec_pkg::CTRL_PS_LSB +: tpec_pkg::PS_W];

  // Each change of the synchronised toggle is one counter step.
  assign cnt_step = sync2_q ^ sync3_q;
  assign cnt_wrap = cnt_step & (cnt_q == {CW{1'b1}});
  assign cnt_d    = cnt_step ? CW'(cnt_q + CW'(1)) : cnt_q;

  assign set_ev[tpec_pkg::STS_EXT] = ext_edge;
  assign set_ev[tpec_pkg::STS_PIN] = pin_edge;
  assign set_ev[tpec_pkg::STS_OVF] = cnt_wrap;

  tpec_prescaler #(
    .PSC_W (tpec_pkg::PSC_W)
  ) u_psc (
    .clk (clk),
    .rst (rst),
    .bus (psc_bus)
  );

  // Bus phase tracking and registered read data; zero wait states.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q        <= 1'b0;
      idx_q       <= '0;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_q        <= acc & hwrite;
      idx_q       <= idx_a;
      hrdata_q    <= (acc & ~hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0; // Only OKAY is ever answered.
    end
  end

  // Software-visible registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= tpec_pkg::CTRL_RESET;
      sts_q  <= tpec_pkg::STS_RESET;
      mask_q <= tpec_pkg::STS_RESET;
      cnt_q  <= '0;
      irq_q  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      sts_q  <= sts_d;
      mask_q <= mask_d;
      cnt_q  <= cnt_d;
      irq_q  <= |(sts_d & mask_d);
    end
  end

  // Edge history, clock divider and the toggle synchroniser.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
      div_q      <= '0;
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      sync3_q    <= 1'b0;
    end else begin
      ext_prev_q <= ext_irq_pin;
      pin_prev_q <= count_clock_pin;
      div_q      <= tpec_pkg::INT_DIV_W'(div_q + 1'b1);
      sync1_q    <= psc_bus.div_toggle;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign irq       = irq_q;

  // A prescaler change reaches the counter two cycles later.
  sequence s_toggle_moves;
    psc_bus.div_toggle != $past(psc_bus.div_toggle);
  endsequence
  sequence s_step_later;
    ##2 cnt_step;
  endsequence

  chk_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
    (acc && !hwrite && idx_a == tpec_pkg::IDX_CTRL) |=>
      (hrdata_q[7:0] == ctrl_q && !hrdata_q[0]))
    else $error("Control read data wrong.");
  chk_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl |=> (ctrl_q == ($past(hwdata[7:0]) & tpec_pkg::CTRL_WMASK)))
    else $error("Control write not stored.");
  chk_ext_edge: assert property (@(posedge clk) disable iff (rst)
    (ext_rise && ctrl_q[tpec_pkg::CTRL_EXT_EDGE]) |=>
      sts_q[tpec_pkg::STS_EXT])
    else $error("Rising external edge not flagged.");
  chk_pin_edge: assert property (@(posedge clk) disable iff (rst)
    (pin_fall && !ctrl_q[tpec_pkg::CTRL_CNT_EDGE]) |=>
      sts_q[tpec_pkg::STS_PIN])
    else $error("Falling pin edge not flagged.");
  chk_src_pin: assert property (@(posedge clk) disable iff (rst)
    !ctrl_q[tpec_pkg::CTRL_SRC] |-> (psc_bus.tick == pin_edge))
    else $error("Pin source not routed.");
  chk_int_rate: assert property (@(posedge clk) disable iff (rst)
    int_tick |=> !int_tick [*3] ##1 int_tick)
    else $error("Internal clock not one in four.");
  chk_sync_delay: assert property (@(posedge clk) disable iff (rst)
    s_toggle_moves |-> s_step_later)
    else $error("Counter step not two cycles after toggle.");
  chk_count_wrap: assert property (@(posedge clk) disable iff (rst)
    cnt_wrap |=> (cnt_q == '0 && sts_q[tpec_pkg::STS_OVF]))
    else $error("Wrap did not clear counter and flag.");
  chk_count_step: assert property (@(posedge clk) disable iff (rst)
    (cnt_step && !cnt_wrap) |=> (cnt_q == CW'($past(cnt_q) + CW'(1))))
    else $error("Counter did not advance by one.");
endmodule

// ### tb/tpec_pin_model.sv
// Pin source model that drives the interrupt and counter clock pins.
`timescale 1ns/100ps
module tpec_pin_model (
  // Clock.
  input  wire logic clk,
  // Pins.
  output logic      ext_irq_pin,
  output logic      count_clock_pin
);
  // Both pins idle low until a scenario moves them.
  initial begin
    ext_irq_pin     = 1'b0;
    count_clock_pin = 1'b0;
  end

  // Flip the counter pin n times; hold sets the cycles per level.
  task automatic toggle_count(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk);
      count_clock_pin <= ~count_clock_pin;
    end
  endtask

  // Move the interrupt pin just after an edge, as a real source would.
  task automatic set_irq(input logic lvl);
    @(posedge clk);
    ext_irq_pin <= lvl;
  endtask
endmodule

// ### tb/timer_prescale_edge_config_tb_top.sv
// Self-checking bench for the counter clock configuration block.
`timescale 1ns/100ps
module timer_prescale_edge_config_tb_top;
  localparam logic [31:0] A_CTRL = {tpec_pkg::IDX_CTRL, 2'h0};
  localparam logic [31:0] A_STS  = {tpec_pkg::IDX_STS, 2'h0};
  localparam logic [31:0] A_MASK = {tpec_pkg::IDX_MASK, 2'h0};
  localparam logic [31:0] A_CNT  = {tpec_pkg::IDX_CNT, 2'h0};
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic        hsel         = 1'b0;
  logic [31:0] haddr        = 32'h0000_0000;
  logic [1:0]  htrans       = 2'h0;
  logic        hwrite       = 1'b0;
  logic [31:0] hwdata       = 32'h0000_0000;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         ext_irq_pin;
  wire         count_clock_pin;
  wire         irq;
  int          failures     = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  logic [31:0] rd;
  logic [31:0] c0;

  // Clock generator and a hang guard.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end

  tpec_top u_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .ext_irq_pin(ext_irq_pin), .count_clock_pin(count_clock_pin),
    .irq(irq)
  );
  tpec_pin_model u_pins (
    .clk(clk), .ext_irq_pin(ext_irq_pin), .count_clock_pin(count_clock_pin)
  );

  // Verdict and end of run.
  task automatic close_out();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare one value against its expectation.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB transfer; waits on hready, read data lands in rd.
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic rdchk(input string what, input logic [31:0] a,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  // Reset values, write mask, bit 0 and an unmapped address.
  task automatic t_regs();
    rdchk("ctrl rst", A_CTRL, 32'h0000_0000);
    rdchk("cnt rst", A_CNT, 32'h0000_0000);
    check("irq rst", 32'h0, {31'h0, irq});
    bus(1'b1, A_CTRL, 32'h0000_00FF);
    rdchk("ctrl ff", A_CTRL, 32'h0000_00FE);
    bus(1'b1, A_CTRL, 32'h0000_002A);
    bus(1'b1, 32'h0000_0040, 32'h0000_00FF);
    rdchk("unmapped", 32'h0000_0040, 32'h0000_0000);
    rdchk("ctrl 2a", A_CTRL, 32'h0000_002A);
  endtask

  // Interrupt pin polarity, sticky status, mask and irq level.
  task automatic t_ext_irq();
    bus(1'b1, A_MASK, 32'h0000_0001);
    rdchk("mask rd", A_MASK, 32'h0000_0001);
    bus(1'b1, A_CTRL, 32'h0000_0080);
    bus(1'b1, A_STS, 32'h0000_0007);
    u_pins.set_irq(1'b1);
    rdchk("rise sel", A_STS, 32'h0000_0001);
    check("irq on", 32'h1, {31'h0, irq});
    bus(1'b1, A_STS, 32'h0000_0001);
    u_pins.set_irq(1'b0);
    rdchk("fall ign", A_STS, 32'h0000_0000);
    check("irq off", 32'h0, {31'h0, irq});
    bus(1'b1, A_CTRL, 32'h0000_0000);
    u_pins.set_irq(1'b1);
    rdchk("rise ign", A_STS, 32'h0000_0000);
    u_pins.set_irq(1'b0);
    bus(1'b1, A_MASK, 32'h0000_0000);
    rdchk("fall sel", A_STS, 32'h0000_0001);
    check("irq mask", 32'h0, {31'h0, irq});
    bus(1'b1, A_STS, 32'h0000_0001);
  endtask

  // Counting edge of the pin; one step at 1:1 for the chosen edge only.
  task automatic edge_step(input logic [31:0] d, input logic [31:0] f);
    bus(1'b1, A_STS, 32'h0000_0007);
    u_pins.toggle_count(1, 2);
    repeat (8) @(posedge clk);
    rdchk("edge cnt", A_CNT, c0 + d);
    rdchk("edge flag", A_STS, f);
  endtask

  task automatic t_edge();
    bus(1'b1, A_CTRL, 32'h0000_0040);
    bus(1'b0, A_CNT, 32'h0);
    c0 = rd;
    edge_step(32'h1, 32'h2);
    edge_step(32'h1, 32'h0);
    bus(1'b1, A_CTRL, 32'h0000_0000);
    edge_step(32'h1, 32'h0);
    edge_step(32'h2, 32'h2);
  endtask

  // Prescale codes 0 to 8 and 15: 2N rising pin edges after warm-up give exactly two steps.
  task automatic t_prescale();
    int n;
    for (int ps = 0; ps < 16; ps++) begin
      if (ps > 8 && ps < 15) continue;
      n = 1 << ((ps > 8) ? 8 : ps);
      bus(1'b1, A_CTRL, 32'h0000_0040 | (ps << 1));
      u_pins.toggle_count(2 * n, 2);
      repeat (8) @(posedge clk);
      bus(1'b0, A_CNT, 32'h0);
      c0 = rd;
      u_pins.toggle_count(4 * n, 2);
      repeat (8) @(posedge clk);
      rdchk("prescale", A_CNT, (c0 + 32'h2) & 32'h0000_FFFF);
    end
  endtask

  // Internal source ticks every four clocks; fast pin edges do not count but still set the pin flag.
  task automatic t_internal();
    logic [31:0] d;
    bus(1'b1, A_CTRL, 32'h0000_0020);
    bus(1'b1, A_STS, 32'h0000_0007);
    bus(1'b0, A_CNT, 32'h0);
    c0 = rd;
    u_pins.toggle_count(400, 1);
    bus(1'b0, A_CNT, 32'h0);
    d = rd - c0;
    check("int rate", 32'h1, {31'h0, d >= 98 && d <= 103});
    rdchk("pin flag", A_STS, 32'h0000_0002);
  endtask

  // A reset in mid-run clears control, mask, status, counter and irq.
  task automatic t_reset();
    bus(1'b1, A_CTRL, 32'h0000_00FE);
    bus(1'b1, A_MASK, 32'h0000_0007);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk("ctrl rerst", A_CTRL, 32'h0000_0000);
    rdchk("mask rerst", A_MASK, 32'h0000_0000);
    rdchk("sts rerst", A_STS, 32'h0000_0000);
    rdchk("cnt rerst", A_CNT, 32'h0000_0000);
    check("irq rerst", 32'h0, {31'h0, irq});
  endtask

  // Main sequence; the overflow wrap needs over 130k cycles, left out.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ext_irq();
    t_edge();
    t_prescale();
    t_internal();
    t_reset();
    close_out();
  end
endmodule
